/* design/burst_ctrl_map.vh */
`ifndef BURST_CTRL_MAP_VH
`define BURST_CTRL_MAP_VH

// Register byte offsets on the AXI4-Lite bus
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_WRITE_BURSTS 5'h08
`define REG_READ_BURSTS 5'h0C
`define REG_LAST_ADDR 5'h10

// Control register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_CLEAR_BIT 1
`define CTRL_RESET_VALUE 2'h1

// Status register fields
`define STATUS_STATE_LSB 0
`define STATUS_STATE_MSB 2
`define STATUS_BEAT_LSB 4
`define STATUS_BEAT_MSB 5

// Memory word layout
`define ADDR_W 20
`define DATA_W 36
`define LANES 4
`define LANE_W 9

// Burst length in beats
`define BURST_BEATS 2'h2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* design/pin_sync.v */
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin inputs
module pin_sync
#(
	parameter W = 1
)
(
	aclk,
	aresetn,
	pin_in,
	pin_out
);
	input wire aclk;
	input wire aresetn;
	input wire [W-1:0] pin_in;
	output wire [W-1:0] pin_out;

	// First stage, read only by the second stage
	reg [W-1:0] meta_r;
	// Second stage, safe for logic
	reg [W-1:0] sync_r;

	// Both stages clear on reset
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign pin_out = sync_r;
endmodule

/* design/lane_mask.v */
`timescale 1ns/1ps
`include "burst_ctrl_map.vh"
// Expands active-low lane enables into a per-bit write mask
module lane_mask
(
	lane_enable_n,
	write_beat,
	bit_mask
);
	input wire [`LANES-1:0] lane_enable_n;
	input wire write_beat;
	output wire [`DATA_W-1:0] bit_mask;

	genvar g;
	// Lane n covers bits 9n to 9n+8, only during a write beat
	generate
		for (g = 0; g < `LANES; g = g + 1)
		begin : lane
			assign bit_mask[g*`LANE_W +: `LANE_W] = {`LANE_W{write_beat & ~lane_enable_n[g]}};
		end
	endgenerate
endmodule

/* design/burst_ctrl.v */
`timescale 1ns/1ps
`include "burst_ctrl_map.vh"

module burst_ctrl
(
	aclk,
	aresetn,
	k_clk,
	k_clk_n,
	cycle_load_n,
	read_write_sel,
	address_high,
	burst_low_address_bit,
	data_in,
	lane0_write_enable_n,
	lane1_write_enable_n,
	lane2_write_enable_n,
	lane3_write_enable_n,
	mem_write_strobe,
	mem_read_strobe,
	mem_addr,
	mem_data,
	mem_bit_enable,
	cycle_end,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready
);
	// Core clock and synchronous active-low reset
	input wire aclk;
	input wire aresetn;
	// Input clock pair from the memory controller
	input wire k_clk;
	input wire k_clk_n;
	// Command pins
	input wire cycle_load_n;
	input wire read_write_sel;
	input wire [`ADDR_W-2:0] address_high;
	input wire burst_low_address_bit;
	// Write data and lane enables
	input wire [`DATA_W-1:0] data_in;
	input wire lane0_write_enable_n;
	input wire lane1_write_enable_n;
	input wire lane2_write_enable_n;
	input wire lane3_write_enable_n;
	// Storage array port
	output reg mem_write_strobe;
	output reg mem_read_strobe;
	output reg [`ADDR_W-1:0] mem_addr;
	output reg [`DATA_W-1:0] mem_data;
	output reg [`DATA_W-1:0] mem_bit_enable;
	// One-cycle pulse when a burst finishes
	output reg cycle_end;
	// AXI4-Lite slave
	input wire [4:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [4:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;

	// One-hot bus cycle states
	localparam ST_IDLE = 3'h1;
	localparam ST_WRITE = 3'h2;
	localparam ST_READ = 3'h4;

	// Width of the synchronised pin group
	localparam SYNC_W = 2 + 2 + `ADDR_W + `DATA_W + `LANES;

	// Synchronised pins
	wire [SYNC_W-1:0] pins_raw;
	wire [SYNC_W-1:0] pins_s;
	wire k_s;
	wire kn_s;
	wire load_n_s;
	wire rw_s;
	wire [`ADDR_W-1:0] addr_s;
	wire [`DATA_W-1:0] data_s;
	wire [`LANES-1:0] lanes_n_s;

	// Edge detection of the input clocks
	reg k_d_r;
	reg kn_d_r;
	wire k_rise;
	wire kn_rise;

	// Bus cycle state
	reg [2:0] state_r;
	reg [1:0] beat_cnt_r;
	reg [`ADDR_W-1:0] load_addr_r;
	wire cycle_done;
	wire accept;
	wire start;

	// Beat mask from the lane expander
	wire write_beat;
	wire [`DATA_W-1:0] beat_mask;

	// Software-visible registers
	reg ctrl_enable_r;
	reg [31:0] write_bursts_r;
	reg [31:0] read_bursts_r;
	reg [`ADDR_W-1:0] last_addr_r;

	// AXI write-side capture
	reg aw_got_r;
	reg w_got_r;
	reg [4:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	wire do_write;
	wire clear_req;

	// Gather all pins so they cross together with equal delay
	assign pins_raw = {k_clk, k_clk_n, cycle_load_n, read_write_sel,
		address_high, burst_low_address_bit, data_in,
		lane3_write_enable_n, lane2_write_enable_n, lane1_write_enable_n, lane0_write_enable_n};

	pin_sync #(.W(SYNC_W)) u_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(pins_raw),
		.pin_out(pins_s)
	);

	// Split the synchronised group back into fields
	assign k_s = pins_s[SYNC_W-1];
	assign kn_s = pins_s[SYNC_W-2];
	assign load_n_s = pins_s[SYNC_W-3];
	assign rw_s = pins_s[SYNC_W-4];
	assign addr_s = pins_s[`DATA_W+`LANES +: `ADDR_W];
	assign data_s = pins_s[`LANES +: `DATA_W];
	assign lanes_n_s = pins_s[`LANES-1:0];

	// Previous clock levels for edge detection
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			k_d_r <= 1'b0;
			kn_d_r <= 1'b0;
		end
		else
		begin
			k_d_r <= k_s;
			kn_d_r <= kn_s;
		end
	end

	assign k_rise = k_s & ~k_d_r;
	assign kn_rise = kn_s & ~kn_d_r;

	// A burst is complete once both beats have been moved
	assign cycle_done = (beat_cnt_r == `BURST_BEATS);
	// Commands are sampled only on K rises when no burst is pending
	assign accept = k_rise & (state_r[0] | cycle_done);
	// Load low starts a cycle while the control enable is set; load high is a no-operation
	assign start = accept & ~load_n_s & ctrl_enable_r;

	// A beat of a write burst is being moved this cycle
	assign write_beat = state_r[1] & ((k_rise & (beat_cnt_r == 2'h0)) | (kn_rise & (beat_cnt_r == 2'h1)));

	lane_mask u_mask
	(
		.lane_enable_n(lanes_n_s),
		.write_beat(write_beat),
		.bit_mask(beat_mask)
	);

	// Bus cycle state machine, stepped by K rises only
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= ST_IDLE;
			load_addr_r <= {`ADDR_W{1'b0}};
		end
		else if (k_rise)
		begin
			case (state_r)
				ST_IDLE, ST_WRITE, ST_READ:
				begin
					if (start)
					begin
						// Latch the single burst address
						state_r <= rw_s ? ST_READ : ST_WRITE;
						load_addr_r <= addr_s;
					end
					else if (accept)
					begin
						// Burst over or no-operation: wait for a command
						state_r <= ST_IDLE;
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Beat counter and storage port, beats on K then K#
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			beat_cnt_r <= 2'h0;
			mem_write_strobe <= 1'b0;
			mem_read_strobe <= 1'b0;
			mem_addr <= {`ADDR_W{1'b0}};
			mem_data <= {`DATA_W{1'b0}};
			mem_bit_enable <= {`DATA_W{1'b0}};
			cycle_end <= 1'b0;
		end
		else
		begin
			mem_write_strobe <= 1'b0;
			mem_read_strobe <= 1'b0;
			cycle_end <= 1'b0;
			if (accept)
			begin
				// New burst or idle: restart the count
				beat_cnt_r <= 2'h0;
				cycle_end <= ~state_r[0];
			end
			else if (k_rise && !state_r[0] && beat_cnt_r == 2'h0)
			begin
				// First beat at the loaded address
				beat_cnt_r <= 2'h1;
				mem_write_strobe <= state_r[1];
				mem_read_strobe <= state_r[2];
				mem_addr <= load_addr_r;
				mem_data <= data_s;
				mem_bit_enable <= beat_mask;
			end
			else if (kn_rise && !state_r[0] && beat_cnt_r == 2'h1)
			begin
				// Second beat at the loaded address with its low bit inverted
				beat_cnt_r <= `BURST_BEATS;
				mem_write_strobe <= state_r[1];
				mem_read_strobe <= state_r[2];
				mem_addr <= {load_addr_r[`ADDR_W-1:1], ~load_addr_r[0]};
				mem_data <= data_s;
				mem_bit_enable <= beat_mask;
			end
		end
	end

	// Burst statistics and last loaded address
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			write_bursts_r <= 32'h0;
			read_bursts_r <= 32'h0;
			last_addr_r <= {`ADDR_W{1'b0}};
		end
		else if (clear_req)
		begin
			write_bursts_r <= 32'h0;
			read_bursts_r <= 32'h0;
		end
		else if (start)
		begin
			// Count each started command unless a counter clear comes in the same cycle
			write_bursts_r <= write_bursts_r + {31'h0, ~rw_s};
			read_bursts_r <= read_bursts_r + {31'h0, rw_s};
			last_addr_r <= addr_s;
		end
	end

	// AXI ready while the matching half is not yet held and no write response is pending
	assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
	// Write happens once address and data are both held
	assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
	// Counter clear is a self-clearing control bit
	assign clear_req = do_write & (awaddr_r == `REG_CTRL) & wstrb_r[0] & wdata_r[`CTRL_CLEAR_BIT];

	// AXI write channel capture and response
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 5'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			ctrl_enable_r <= 1'b1;
		end
		else
		begin
			// Address and data may arrive in either order
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[4:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Only the control word is writable
				if (awaddr_r == `REG_CTRL)
				begin
					s_axi_bresp <= `RESP_OKAY;
					if (wstrb_r[0])
						ctrl_enable_r <= wdata_r[`CTRL_ENABLE_BIT];
				end
				else if (awaddr_r == `REG_STATUS || awaddr_r == `REG_WRITE_BURSTS ||
					awaddr_r == `REG_READ_BURSTS || awaddr_r == `REG_LAST_ADDR)
				begin
					// Read-only words ignore writes
					s_axi_bresp <= `RESP_OKAY;
				end
				else
				begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read address taken whenever no answer is pending
	assign s_axi_arready = ~s_axi_rvalid;

	// AXI read channel, answer one cycle after the address
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case ({s_axi_araddr[4:2], 2'h0})
				`REG_CTRL:
					s_axi_rdata <= {31'h0, ctrl_enable_r};
				`REG_STATUS:
					s_axi_rdata <= {26'h0, beat_cnt_r, 1'b0, state_r};
				`REG_WRITE_BURSTS:
					s_axi_rdata <= write_bursts_r;
				`REG_READ_BURSTS:
					s_axi_rdata <= read_bursts_r;
				`REG_LAST_ADDR:
					s_axi_rdata <= {12'h0, last_addr_r};
				default:
				begin
					// Unmapped word reads zero with an error
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* tb/burst_ctrl_sva.sv */
`timescale 1ns/1ps
// Watches the beat outputs of the burst controller
module burst_ctrl_sva
(
	input wire aclk,
	input wire aresetn,
	input wire mem_write_strobe,
	input wire mem_read_strobe,
	input wire [19:0] mem_addr,
	input wire [35:0] mem_bit_enable,
	input wire cycle_end
);
	reg odd_r; // High between first and second beat
	reg [19:0] first_r; // Address of the last beat
	wire beat = mem_write_strobe | mem_read_strobe;
	// Beat parity and address tracker
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			odd_r <= 1'b0;
			first_r <= 20'h00000;
		end
		else if (beat)
		begin
			odd_r <= ~odd_r;
			first_r <= mem_addr;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_one_kind: assert property (!(mem_write_strobe && mem_read_strobe))
		else $error("write and read beat together");
	chk_read_mask: assert property (mem_read_strobe |-> mem_bit_enable == 36'h0)
		else $error("read beat with write mask");
	chk_lane_whole: assert property (mem_write_strobe |-> mem_bit_enable ==
		{{9{mem_bit_enable[27]}}, {9{mem_bit_enable[18]}}, {9{mem_bit_enable[9]}}, {9{mem_bit_enable[0]}}})
		else $error("lane mask split");
	chk_second_addr: assert property (beat && odd_r |-> mem_addr == (first_r ^ 20'h00001))
		else $error("second beat address wrong");
	chk_beat_gap: assert property (beat |=> !beat [*3])
		else $error("beats closer than half a link period");
	chk_second_soon: assert property (beat && !odd_r |-> ##[3:5] beat)
		else $error("second beat late");
	chk_end_even: assert property (cycle_end |-> !odd_r)
		else $error("cycle ended mid burst");
	chk_end_after: assert property (beat && odd_r |-> ##[2:6] cycle_end)
		else $error("cycle end missing");
	chk_end_pulse: assert property (cycle_end |=> !cycle_end)
		else $error("cycle end too long");
	cover property (mem_write_strobe && mem_bit_enable == 36'hFFFFFFFFF);
	cover property (mem_read_strobe);
	cover property (cycle_end);
endmodule
bind burst_ctrl burst_ctrl_sva chk_u
(
	.aclk(aclk),
	.aresetn(aresetn),
	.mem_write_strobe(mem_write_strobe),
	.mem_read_strobe(mem_read_strobe),
	.mem_addr(mem_addr),
	.mem_bit_enable(mem_bit_enable),
	.cycle_end(cycle_end)
);

/* tb/mem_ctrl_model.sv */
`timescale 1ns/1ps
// Memory controller side: input clock pair, command and beat data
module mem_ctrl_model
(
	output reg k_clk,
	output reg k_clk_n,
	output reg cycle_load_n,
	output reg rw,
	output reg [19:0] addr,
	output reg [35:0] data,
	output reg [3:0] lane_n
);
	// Free-running clock pair, started after reset
	initial
	begin
		k_clk = 1'b0;
		k_clk_n = 1'b1;
		cycle_load_n = 1'b1; // Idle is a no-operation
		rw = 1'b1;
		addr = 20'h00000;
		data = 36'h000000000;
		lane_n = 4'h0;
		#613;
		forever
		begin
			#200 k_clk = ~k_clk;
			k_clk_n = ~k_clk_n;
		end
	end
	// Waits n periods, ends midway before a K rise
	task idle(input integer n);
	begin
		repeat (n) @(posedge k_clk_n);
		#100;
	end
	endtask
	// Command, beat on K, beat on K#, then data and lane enables driven inverted
	task burst(input rd, input [19:0] a, input [35:0] d1, input [3:0] e1, input [35:0] d2, input [3:0] e2);
	begin
		cycle_load_n = 1'b0; // Held across the K rise
		rw = rd;
		addr = a; // One address per burst
		@(posedge k_clk);
		#100;
		cycle_load_n = 1'b1;
		addr = ~a;
		data = d1;
		lane_n = e1; // Enables of first beat
		@(posedge k_clk);
		#100;
		data = d2;
		lane_n = e2; // Enables of second beat
		@(posedge k_clk_n);
		#100;
		data = ~d2;
		lane_n = ~e2;
	end
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "burst_ctrl_map.vh"
// Drives bursts and register accesses, checks beats and counters
module testbench;
	reg aclk;
	reg aresetn;
	reg [4:0] awaddr;
	reg [4:0] araddr;
	reg [31:0] wdata;
	reg [3:0] wstrb; // Byte strobes of the register write
	reg awv, wv, bready, arv, rready;
	wire awready, wready, bvalid, arready, rvalid, k, kn, ld_n, rw, ws, rs, ce;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [19:0] pa, ma;
	wire [35:0] pd, md, mm;
	wire [3:0] pe;
	integer num_errors = 0;
	integer checks = 0;
	integer i;
	reg [92:0] beats[$]; // Seen beats: read flag, address, data, mask
	localparam [23:0] PAT = 24'hF7BDE0; // First-beat lane enables
	burst_ctrl dut_u
	(
		.aclk(aclk), .aresetn(aresetn), .k_clk(k), .k_clk_n(kn), .cycle_load_n(ld_n),
		.read_write_sel(rw), .address_high(pa[19:1]), .burst_low_address_bit(pa[0]), .data_in(pd),
		.lane0_write_enable_n(pe[0]), .lane1_write_enable_n(pe[1]), .lane2_write_enable_n(pe[2]),
		.lane3_write_enable_n(pe[3]), .mem_write_strobe(ws), .mem_read_strobe(rs), .mem_addr(ma),
		.mem_data(md), .mem_bit_enable(mm), .cycle_end(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	mem_ctrl_model model_u
	(
		.k_clk(k), .k_clk_n(kn), .cycle_load_n(ld_n), .rw(rw), .addr(pa), .data(pd), .lane_n(pe)
	);
	// Core clock
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Records every beat
	always @(posedge aclk)
		if (ws | rs) beats.push_back({rs, ma, md, mm});
	// Compares and counts
	task chk(input string name, input [92:0] seen, input [92:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("Error %0s expected %h seen %h", name, exp, seen);
		end
	end
	endtask
	// Expected mask from active-low lane enables
	function [35:0] mask(input [3:0] e);
		integer n;
	begin
		mask = 36'h0;
		for (n = 0; n < 4; n = n + 1)
			mask[9*n +: 9] = {9{~e[n]}};
	end
	endfunction
	// Pops one beat; read data is ignored
	task beat(input rd, input [19:0] a, input [35:0] d, input [35:0] m);
		reg [92:0] s;
	begin
		s = (beats.size() != 0) ? beats.pop_front() : 93'h0;
		if (rd) s[71:36] = 36'h0;
		chk("beat", s, {rd, a, d, m});
	end
	endtask
	// Register write
	task wr(input [4:0] a, input [31:0] d, input [1:0] er);
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awv <= 1'b0;
			if (wready) wv <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk("bresp", bresp, er);
	end
	endtask
	// Register read
	task rd(input [4:0] a, input [31:0] ed, input [1:0] er);
	begin
		@(posedge aclk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arv <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		chk("rdata", {rresp, rdata}, {er, ed});
	end
	endtask
	// Verdict
	task summarize;
	begin
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// Watchdog
	initial
	begin
		#200000;
		num_errors = num_errors + 1;
		$display("Error watchdog expired");
		summarize;
	end
	// Test sequence
	initial
	begin
		{aresetn, awv, wv, bready, arv, rready} = 6'h0;
		{awaddr, araddr, wdata} = 42'h0;
		wstrb = 4'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`REG_CTRL, 32'h1, `RESP_OKAY);
		rd(`REG_STATUS, 32'h1, `RESP_OKAY);
		rd(`REG_WRITE_BURSTS, 32'h0, `RESP_OKAY);
		rd(5'h14, 32'h0, `RESP_SLVERR);
		wr(5'h14, 32'h0, `RESP_SLVERR);
		wr(`REG_STATUS, 32'hFF, `RESP_OKAY);
		rd(`REG_STATUS, 32'h1, `RESP_OKAY);
		$display("test registers done");
		model_u.idle(1);
		for (i = 0; i < 6; i = i + 1)
			model_u.burst(0, 20'h0F000 + i, 36'h123456789 + i, PAT[4*i +: 4], 36'hABC000000 + i, ~PAT[4*i +: 4]);
		model_u.idle(2);
		for (i = 0; i < 6; i = i + 1)
		begin
			beat(0, 20'h0F000 + i, 36'h123456789 + i, mask(PAT[4*i +: 4]));
			beat(0, (20'h0F000 + i) ^ 20'h1, 36'hABC000000 + i, mask(~PAT[4*i +: 4]));
		end
		rd(`REG_WRITE_BURSTS, 32'h6, `RESP_OKAY);
		rd(`REG_LAST_ADDR, 32'h0F005, `RESP_OKAY);
		$display("test write bursts done");
		model_u.burst(1, 20'hABCDF, 36'h0, 4'h0, 36'h0, 4'hF);
		model_u.idle(3);
		beat(1, 20'hABCDF, 36'h0, 36'h0);
		beat(1, 20'hABCDE, 36'h0, 36'h0);
		chk("extra beats", beats.size(), 0);
		rd(`REG_READ_BURSTS, 32'h1, `RESP_OKAY);
		$display("test read burst done");
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		model_u.idle(1);
		model_u.burst(0, 20'h00010, 36'h1, 4'h0, 36'h2, 4'h0);
		model_u.idle(2);
		chk("disabled beats", beats.size(), 0);
		wr(`REG_CTRL, 32'h3, `RESP_OKAY);
		rd(`REG_WRITE_BURSTS, 32'h0, `RESP_OKAY);
		rd(`REG_CTRL, 32'h1, `RESP_OKAY);
		$display("test disable and clear done");
		summarize;
	end
endmodule
